//--- verilog/tdrs_defines.svh
// Link address map, command codes and crossing timing for the debug
// link register select block. Definitions only.
`ifndef TDRS_DEFINES_SVH
`define TDRS_DEFINES_SVH

`define TDRS_SEL_PART_ID 8'h00
`define TDRS_SEL_REV_ID 8'h01
`define TDRS_SEL_FLASH_CTL 8'h02
`define TDRS_SEL_FLASH_DAT 8'hB4
`define TDRS_ADDR_PART_ID 8'hFD
`define TDRS_ADDR_REV_ID 8'hFE
`define TDRS_SFR_PAGE_ID 4'hF
`define TDRS_SEL_RESET 8'h00
`define TDRS_FLASH_KEY1 8'h02
`define TDRS_FLASH_KEY2 8'h01
`define TDRS_FCMD_BLOCK_READ 8'h06
`define TDRS_FCMD_BLOCK_WRITE 8'h07
`define TDRS_FCMD_PAGE_ERASE 8'h08
`define TDRS_FCMD_DEVICE_ERASE 8'h03
`define TDRS_CMD_ADDR_WRITE 2'h0
`define TDRS_CMD_ADDR_READ 2'h1
`define TDRS_CMD_DATA_WRITE 2'h2
`define TDRS_CMD_DATA_READ 2'h3
`define TDRS_XFER_MAX_CYCLES 4

`endif

//--- verilog/tdrs_pkg.sv
// Types shared by the debug link register select block.
// Assumes tdrs_defines.svh carries the numbers.
package tdrs_pkg;

    typedef enum logic [2:0] {
        TDRS_IDLE,
        TDRS_CMD,
        TDRS_WDATA,
        TDRS_TURN,
        TDRS_RDATA
    } tdrs_state_type;

    // Write carried from the link domain to the core domain
    typedef struct packed {
        logic to_data;
        logic [7:0] value;
    } tdrs_xfer_type;

    // Flash programming view handed to the flash engine
    typedef struct packed {
        logic prog_enabled;
        logic [7:0] control;
        logic [7:0] data;
    } tdrs_flash_type;

endpackage : tdrs_pkg

//--- verilog/tdrs_top.sv
// Register select logic behind the two-wire debug link.
// Assumes the host also clocks link_clk outside frames with data high, samples read bits
// on link_clk rising edges, and keeps link writes at least 4 core clocks
// apart (one frame is far longer).
`timescale 1ns/1ps
`include "tdrs_defines.svh"

module tdrs_top
    import tdrs_pkg::*;
#(
    parameter logic [7:0] PART_ID = 8'hA5, // Arbitrary value
    parameter logic [7:0] REV_ID = 8'h5A // Arbitrary value
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic link_clk,
    input wire logic link_data_in,
    output logic link_data_out,
    output logic link_data_oe_n,
    input wire logic [7:0] sfr_addr,
    input wire logic [3:0] sfr_page,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    output tdrs_flash_type flash_out,
    output logic flash_data_wr
);

    // Link domain reset: asserted at once, released on link_clk
    logic [1:0] link_rst_reg;
    logic link_rst_n;

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            link_rst_reg <= 2'b00;
        end else begin
            link_rst_reg <= {link_rst_reg[0], 1'b1};
        end
    end
    assign link_rst_n = link_rst_reg[1];

    tdrs_state_type state_reg;
    logic [3:0] bit_cnt_reg;
    logic [1:0] cmd_reg;
    logic [7:0] shift_reg;
    logic [7:0] target_select_reg;
    logic [7:0] link_ctl_reg;
    logic [7:0] link_dat_reg;
    logic [7:0] read_value;
    logic frame_last;
    tdrs_xfer_type xfer_hold_reg;
    logic xfer_tog_reg;

    always_comb begin
        read_value = 8'h00;
        if (target_select_reg == `TDRS_SEL_PART_ID ||
            target_select_reg == `TDRS_ADDR_PART_ID) begin
            read_value = PART_ID;
        end else if (target_select_reg == `TDRS_SEL_REV_ID ||
                     target_select_reg == `TDRS_ADDR_REV_ID) begin
            read_value = REV_ID;
        end else if (target_select_reg == `TDRS_SEL_FLASH_CTL) begin
            read_value = link_ctl_reg;
        end else if (target_select_reg == `TDRS_SEL_FLASH_DAT) begin
            read_value = link_dat_reg;
        end
    end

    assign frame_last = (bit_cnt_reg == 4'h7);

    // Frame sequencer; start bit low, 2 command bits, 8 data bits
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            state_reg <= TDRS_IDLE;
            bit_cnt_reg <= 4'h0;
            cmd_reg <= 2'b00;
            shift_reg <= 8'h00;
        end else begin
            case (state_reg)
                TDRS_IDLE: begin
                    bit_cnt_reg <= 4'h0;
                    if (!link_data_in) begin
                        state_reg <= TDRS_CMD;
                    end
                end
                TDRS_CMD: begin
                    cmd_reg <= {link_data_in, cmd_reg[1]};
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (bit_cnt_reg == 4'h1) begin
                        bit_cnt_reg <= 4'h0;
                        state_reg <= link_data_in ? TDRS_WDATA : TDRS_WDATA;
                        if ({link_data_in, cmd_reg[1]} ==
                            `TDRS_CMD_ADDR_READ ||
                            {link_data_in, cmd_reg[1]} ==
                            `TDRS_CMD_DATA_READ) begin
                            state_reg <= TDRS_TURN;
                        end
                    end
                end
                TDRS_WDATA: begin
                    shift_reg <= {link_data_in, shift_reg[7:1]};
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (frame_last) begin
                        state_reg <= TDRS_IDLE;
                    end
                end
                TDRS_TURN: begin
                    shift_reg <= (cmd_reg == `TDRS_CMD_ADDR_READ) ?
                                 target_select_reg : read_value;
                    state_reg <= TDRS_RDATA;
                end
                TDRS_RDATA: begin
                    shift_reg <= {1'b0, shift_reg[7:1]};
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (frame_last) begin
                        state_reg <= TDRS_IDLE;
                    end
                end
                default: begin
                    state_reg <= TDRS_IDLE;
                end
            endcase
        end
    end

    // Device drives the line only while sending read bits
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            link_data_out <= 1'b1;
            link_data_oe_n <= 1'b1;
        end else begin
            link_data_oe_n <= 1'b1;
            link_data_out <= 1'b1;
            if (state_reg == TDRS_TURN) begin
                link_data_oe_n <= 1'b0;
                link_data_out <= (cmd_reg == `TDRS_CMD_ADDR_READ) ?
                                 target_select_reg[0] : read_value[0];
            end else if (state_reg == TDRS_RDATA && !frame_last) begin
                link_data_oe_n <= 1'b0;
                link_data_out <= shift_reg[1];
            end
        end
    end

    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            target_select_reg <= `TDRS_SEL_RESET;
        end else if (state_reg == TDRS_WDATA && frame_last &&
                     cmd_reg == `TDRS_CMD_ADDR_WRITE) begin
            target_select_reg <= {link_data_in, shift_reg[7:1]};
        end
    end

    // Only the flash registers take data writes
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            link_ctl_reg <= 8'h00;
            link_dat_reg <= 8'h00;
            xfer_hold_reg <= '0;
            xfer_tog_reg <= 1'b0;
        end else if (state_reg == TDRS_WDATA && frame_last &&
                     cmd_reg == `TDRS_CMD_DATA_WRITE) begin
            if (target_select_reg == `TDRS_SEL_FLASH_CTL) begin
                link_ctl_reg <= {link_data_in, shift_reg[7:1]};
                xfer_hold_reg <= {1'b0, link_data_in, shift_reg[7:1]};
                xfer_tog_reg <= ~xfer_tog_reg;
            end else if (target_select_reg == `TDRS_SEL_FLASH_DAT) begin
                // Command, address or data byte to flash engine
                link_dat_reg <= {link_data_in, shift_reg[7:1]};
                xfer_hold_reg <= {1'b1, link_data_in, shift_reg[7:1]};
                xfer_tog_reg <= ~xfer_tog_reg;
            end
        end
    end

    // Core domain: toggle synchroniser, hold word stable meanwhile
    logic [2:0] tog_sync_reg;
    logic xfer_seen;
    logic [7:0] last_ctl_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tog_sync_reg <= 3'b000;
        end else begin
            tog_sync_reg <= {tog_sync_reg[1:0], xfer_tog_reg};
        end
    end
    assign xfer_seen = tog_sync_reg[2] ^ tog_sync_reg[1];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flash_out <= '0;
            flash_data_wr <= 1'b0;
            last_ctl_reg <= 8'h00;
        end else begin
            flash_data_wr <= xfer_seen && xfer_hold_reg.to_data;
            if (xfer_seen && xfer_hold_reg.to_data) begin
                flash_out.data <= xfer_hold_reg.value;
            end else if (xfer_seen) begin
                flash_out.control <= xfer_hold_reg.value;
                last_ctl_reg <= xfer_hold_reg.value;
                // Key pair enables programming until reset
                if (last_ctl_reg == `TDRS_FLASH_KEY1 &&
                    xfer_hold_reg.value == `TDRS_FLASH_KEY2) begin
                    flash_out.prog_enabled <= 1'b1;
                end
            end
        end
    end

    // Software view of identity and revision on page 0xF
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata <= 8'h00;
            if (sfr_page == `TDRS_SFR_PAGE_ID &&
                sfr_addr == `TDRS_ADDR_PART_ID) begin
                sfr_rdata <= PART_ID;
            end else if (sfr_page == `TDRS_SFR_PAGE_ID &&
                         sfr_addr == `TDRS_ADDR_REV_ID) begin
                sfr_rdata <= REV_ID;
            end
        end
    end

    // Helper: cycles since a crossing toggle was seen at the far side
    logic [3:0] xfer_age_reg;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            xfer_age_reg <= 4'h0;
        end else if (tog_sync_reg[1] != tog_sync_reg[2]) begin
            xfer_age_reg <= 4'h0;
        end else if (xfer_age_reg != 4'hF) begin
            xfer_age_reg <= xfer_age_reg + 4'h1;
        end
    end

    sel_reset_a: assert property (
        @(posedge link_clk) disable iff (!link_rst_n)
        $rose(link_rst_n) |-> target_select_reg == `TDRS_SEL_RESET)
        else $error("select not zero after reset");

    sel_load_a: assert property (
        @(posedge link_clk) disable iff (!link_rst_n)
        (state_reg == TDRS_WDATA && frame_last &&
         cmd_reg == `TDRS_CMD_ADDR_WRITE)
        |=> target_select_reg == (($past(shift_reg) >> 1) |
            {$past(link_data_in), 7'h00}))
        else $error("select write lost");

    id_read_a: assert property (
        @(posedge link_clk) disable iff (!link_rst_n)
        (state_reg == TDRS_TURN && cmd_reg == `TDRS_CMD_DATA_READ &&
         target_select_reg == `TDRS_SEL_PART_ID)
        |=> shift_reg == PART_ID && !link_data_oe_n)
        else $error("identity not returned");

    rev_read_a: assert property (
        @(posedge link_clk) disable iff (!link_rst_n)
        (state_reg == TDRS_TURN && cmd_reg == `TDRS_CMD_DATA_READ &&
         target_select_reg == `TDRS_SEL_REV_ID)
        |=> shift_reg == REV_ID)
        else $error("revision not returned");

    drive_turns_a: assert property (
        @(posedge link_clk) disable iff (!link_rst_n)
        (state_reg == TDRS_IDLE || state_reg == TDRS_CMD ||
         state_reg == TDRS_WDATA) |=> link_data_oe_n)
        else $error("device drove line out of turn");

    ro_hold_a: assert property (
        @(posedge link_clk) disable iff (!link_rst_n)
        (state_reg == TDRS_WDATA && frame_last &&
         target_select_reg != `TDRS_SEL_FLASH_CTL)
        |=> $stable(link_ctl_reg))
        else $error("control changed by foreign write");

    xfer_time_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        $rose(xfer_seen) && !xfer_hold_reg.to_data
        |=> flash_out.control == $past(xfer_hold_reg.value))
        else $error("control write not delivered");

    xfer_bound_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        flash_data_wr |-> xfer_age_reg == 4'h0 &&
            flash_out.data == xfer_hold_reg.value)
        else $error("data write pulse out of step");

    sfr_id_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        sfr_rd && sfr_page == `TDRS_SFR_PAGE_ID &&
        sfr_addr == `TDRS_ADDR_PART_ID |=> sfr_rdata == PART_ID)
        else $error("software identity read wrong");

    sfr_rev_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        sfr_rd && sfr_page == `TDRS_SFR_PAGE_ID &&
        sfr_addr == `TDRS_ADDR_REV_ID |=> sfr_rdata == REV_ID)
        else $error("software revision read wrong");

endmodule : tdrs_top

//--- verification/tdrs_host_model.sv
// Behavioural debug host: clocks the link and shares the data line.
// Assumes the device drives the line only while its enable is low.
`timescale 1ns/1ps
module tdrs_host_model (
    output logic link_clk,
    output logic link_data_in,
    input wire logic link_data_out,
    input wire logic link_data_oe_n
);
    logic drv_en;
    logic drv_val;
    logic float_val;
    assign link_data_in = !link_data_oe_n ? link_data_out :
        (drv_en ? drv_val : float_val);
    // No pull on the line, so a released line keeps moving
    always @(negedge link_clk) float_val <= ~float_val;
    initial begin
        link_clk = 1'b0;
        drv_en = 1'b1;
        drv_val = 1'b1;
        float_val = 1'b0;
    end
    // One link clock, 32 ns; sample just before the rising edge
    task automatic edge_bit(input logic en, input logic v, output logic seen);
        drv_en = en;
        drv_val = v;
        #16;
        seen = link_data_in;
        link_clk = 1'b1;
        #16;
        link_clk = 1'b0;
    endtask : edge_bit
    task automatic idle(input int n);
        logic s;
        repeat (n) edge_bit(1'b1, 1'b1, s);
    endtask : idle
    task automatic frame(input logic [1:0] cmd, input logic [7:0] wdata,
                         output logic [7:0] rdata);
        logic s;
        rdata = 8'h00;
        edge_bit(1'b1, 1'b0, s);
        edge_bit(1'b1, cmd[0], s);
        edge_bit(1'b1, cmd[1], s);
        if (cmd[0] == 1'b0) begin
            for (int i = 0; i < 8; i++) edge_bit(1'b1, wdata[i], s);
        end else begin
            edge_bit(1'b0, 1'b0, s);
            for (int i = 0; i < 8; i++) begin
                edge_bit(1'b0, 1'b0, s);
                rdata[i] = s;
            end
        end
        edge_bit(1'b1, 1'b1, s);
    endtask : frame
endmodule : tdrs_host_model

//--- verification/tdrs_top_test.sv
// Self-checking bench for the debug link register select block.
// Assumes the host model drives the link; software port driven here.
`timescale 1ns/1ps
`include "tdrs_defines.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    miscompares++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tdrs_top_test
    import tdrs_pkg::*;
;
    localparam logic [7:0] PID = 8'h3C;
    localparam logic [7:0] RID = 8'hC3;
    logic clk = 1'b0;
    logic arst_n;
    logic link_clk;
    logic link_data_in;
    logic link_data_out;
    logic link_data_oe_n;
    logic [7:0] sfr_addr;
    logic [3:0] sfr_page;
    logic sfr_rd;
    logic [7:0] sfr_rdata;
    tdrs_flash_type flash_out;
    logic flash_data_wr;
    logic [7:0] rd;
    int miscompares = 0;
    int num_checks = 0;
    int wr_pulses = 0;
    int p;
    logic [7:0] sels [5] = '{8'h00, 8'h01, 8'hFD, 8'hFE, 8'h55};
    logic [7:0] exps [5] = '{PID, RID, PID, RID, 8'h00};
    logic [7:0] cmds [4] = '{`TDRS_FCMD_BLOCK_READ, `TDRS_FCMD_BLOCK_WRITE,
        `TDRS_FCMD_PAGE_ERASE, `TDRS_FCMD_DEVICE_ERASE};
    always #25 clk = ~clk;
    tdrs_top #(.PART_ID(PID), .REV_ID(RID)) DUT (.clk(clk), .arst_n(arst_n),
        .link_clk(link_clk), .link_data_in(link_data_in),
        .link_data_out(link_data_out), .link_data_oe_n(link_data_oe_n),
        .sfr_addr(sfr_addr), .sfr_page(sfr_page), .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata), .flash_out(flash_out),
        .flash_data_wr(flash_data_wr));
    tdrs_host_model host (.link_clk(link_clk), .link_data_in(link_data_in),
        .link_data_out(link_data_out), .link_data_oe_n(link_data_oe_n));
    always @(posedge clk) if (flash_data_wr === 1'b1) wr_pulses++;
    task automatic addr_wr(input logic [7:0] v);
        host.frame(`TDRS_CMD_ADDR_WRITE, v, rd);
    endtask : addr_wr
    // Crossing takes 3-4 core clocks; wait well past it
    task automatic data_wr(input logic [7:0] v);
        host.frame(`TDRS_CMD_DATA_WRITE, v, rd);
        repeat (2 * `TDRS_XFER_MAX_CYCLES + 2) @(posedge clk);
    endtask : data_wr
    task automatic link_rd(input logic [1:0] c, input logic [7:0] e);
        host.frame(c, 8'h00, rd);
        `CHK("link read", e, rd)
    endtask : link_rd
    task automatic sfr_chk(input logic [3:0] pg, input logic [7:0] a,
                           input logic [7:0] e);
        @(posedge clk);
        #2 sfr_page = pg;
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge clk);
        #2 sfr_rd = 1'b0;
        `CHK("sfr read", e, sfr_rdata)
    endtask : sfr_chk
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    initial begin
        #200000;
        miscompares++;
        final_report();
    end
    initial begin
        arst_n = 1'b0;
        sfr_addr = 8'h00;
        sfr_page = 4'h0;
        sfr_rd = 1'b0;
        repeat (3) @(posedge clk);
        #2 arst_n = 1'b1;
        host.idle(3);
        `CHK("flash_out", 17'h0_0000, flash_out)
        `CHK("oe_n", 1'b1, link_data_oe_n)
        link_rd(`TDRS_CMD_ADDR_READ, `TDRS_SEL_RESET);
        $display("test reset done");
        foreach (sels[i]) begin
            addr_wr(sels[i]);
            link_rd(`TDRS_CMD_ADDR_READ, sels[i]);
            link_rd(`TDRS_CMD_DATA_READ, exps[i]);
        end
        $display("test select done");
        for (int i = 0; i < 2; i++) begin
            addr_wr(sels[i]);
            data_wr(8'hFF);
            link_rd(`TDRS_CMD_DATA_READ, exps[i]);
        end
        $display("test read-only done");
        addr_wr(`TDRS_SEL_FLASH_CTL);
        data_wr(`TDRS_FLASH_KEY1);
        `CHK("prog_enabled", 1'b0, flash_out.prog_enabled)
        data_wr(`TDRS_FLASH_KEY2);
        `CHK("prog_enabled", 1'b1, flash_out.prog_enabled)
        `CHK("control", `TDRS_FLASH_KEY2, flash_out.control)
        link_rd(`TDRS_CMD_DATA_READ, `TDRS_FLASH_KEY2);
        $display("test flash control done");
        addr_wr(`TDRS_SEL_FLASH_DAT);
        foreach (cmds[i]) begin
            p = wr_pulses;
            data_wr(cmds[i]);
            `CHK("data", cmds[i], flash_out.data)
            `CHK("wr pulses", p + 1, wr_pulses)
            link_rd(`TDRS_CMD_DATA_READ, cmds[i]);
        end
        `CHK("control", `TDRS_FLASH_KEY2, flash_out.control)
        $display("test flash data done");
        sfr_chk(`TDRS_SFR_PAGE_ID, `TDRS_ADDR_PART_ID, PID);
        sfr_chk(`TDRS_SFR_PAGE_ID, `TDRS_ADDR_REV_ID, RID);
        sfr_chk(4'h0, `TDRS_ADDR_PART_ID, 8'h00);
        sfr_chk(`TDRS_SFR_PAGE_ID, 8'hFC, 8'h00);
        $display("test software port done");
        final_report();
    end
endmodule : tdrs_top_test
